// ### src/tpp_pkg.sv
// package: register map, field layout and mode codes of the polarity/prescaler timer
package tpp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTL1 = 8'h00;
  localparam logic [7:0] ADDR_CTL0 = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_PWM = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
  // timer_control_one fields
  localparam int CTL1_EN_BIT = 7;
  localparam int CTL1_POL_BIT = 6;
  localparam int CTL1_PRESCALE_SELECT_LSB = 3;
  localparam int CTL1_MODE_LSB = 0;
  localparam logic [7:0] CTL1_RESET = 8'h00;
  // control zero fields
  localparam int CTL0_MODE3_BIT = 7;
  localparam int CTL0_DB_LSB = 1;
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] PWM_RESET = 16'h0000;
  localparam logic [15:0] COUNT_INIT = 16'h0001;
  // interrupt status bits
  localparam int IRQ_RELOAD = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_GATE = 2;
  localparam int IRQ_N = 3;

  typedef enum logic [3:0] {
    TPP_ONESHOT = 4'b0000,
    TPP_CONT = 4'b0001,
    TPP_COUNTER = 4'b0010,
    TPP_PWM1 = 4'b0011,
    TPP_CAPT = 4'b0100,
    TPP_CMP = 4'b0101,
    TPP_GATED = 4'b0110,
    TPP_CAPCMP = 4'b0111,
    TPP_PWM2 = 4'b1000,
    TPP_CAPRST = 4'b1001,
    TPP_CMPCNT = 4'b1010,
    TPP_TRIG = 4'b1011
  } tpp_mode_e;
endpackage : tpp_pkg

// ### src/tpp_timer.sv
// timer with polarity-selected input edges, output polarity, prescaler and deadband
// Overview of operation
// - disabled timer holds output at the polarity bit value
// - one-shot mode inverts output for one clock after reload
// - continuous and most other modes toggle output at each reload
// - counter mode counts rising input edges, or falling when polarity set
// - capture modes capture count on polarity-selected input edge
// - gated mode counts while input equals inverse of polarity bit
// - gated mode interrupts on the edge ending the active gate level
// - capture/compare starts counting on first polarity-selected edge
// - capture/compare captures count on each later edge of same direction
// - single PWM drives one level at match, opposite level at reload
// - dual PWM drives complement output inverse of primary output
// - dual PWM deadband delays only low-to-high transitions of both outputs
// - triggered one-shot starts on polarity-selected input transition
// - prescaler divides input clock by two to the prescale_select value
// - prescaler state cleared while timer disabled
// - deadband of zero adds none, else two to field value clocks
module tpp_timer
  import tpp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic timer_in_i,
  output logic timer_out_o,
  output logic timer_out_n_o,
  // interrupt
  output logic irq_o
);
  logic [7:0] timer_control_one;
  logic [7:0] ctl0;
  logic [15:0] reload_val;
  logic [15:0] pwm_val;
  logic [15:0] count;
  logic [15:0] capture;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_en;
  logic in_s1, in_s2, in_prev;
  logic [6:0] prescale_select_cnt;
  logic [7:0] db_cnt;
  logic out_raw, out_q, outn_q;
  logic started;
  logic [31:0] next_dat;

  wire logic enabled = timer_control_one[CTL1_EN_BIT];
  wire logic io_polarity_bit = timer_control_one[CTL1_POL_BIT];
  wire logic [2:0] prescale_select = timer_control_one[CTL1_PRESCALE_SELECT_LSB +: 3];
  wire logic [2:0] deadband_delay_field = ctl0[CTL0_DB_LSB +: 3];
  wire tpp_mode_e mode = tpp_mode_e'({ctl0[CTL0_MODE3_BIT], timer_control_one[CTL1_MODE_LSB +: 3]});

  wire logic wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire logic rd_req = cyc_i && stb_i && !ack_o;

  // input edges after two-stage synchroniser
  wire logic rise = in_s2 && !in_prev;
  wire logic fall = !in_s2 && in_prev;
  wire logic act_edge = io_polarity_bit ? fall : rise;
  wire logic gate_end = io_polarity_bit ? rise : fall;
  wire logic gate_on = in_s2 ^ io_polarity_bit;

  // prescaler tick: 2^prescale_select clocks
  wire logic [6:0] prescale_select_mask = 7'((8'h01 << prescale_select) - 8'h01);
  wire logic prescale_select_tick = (prescale_select_cnt & prescale_select_mask) == prescale_select_mask;

  logic count_en;
  always_comb begin
    case (mode)
      TPP_COUNTER: count_en = act_edge;
      TPP_GATED: count_en = prescale_select_tick && gate_on;
      TPP_CAPCMP, TPP_TRIG: count_en = prescale_select_tick && started;
      default: count_en = prescale_select_tick;
    endcase
  end

  wire logic reload = enabled && count_en && (count == reload_val);
  wire logic pwm_match = enabled && count_en && (count == pwm_val);
  wire logic cap_mode = (mode == TPP_CAPT) || (mode == TPP_CAPRST) || (mode == TPP_CMPCNT);
  wire logic cap_evt = enabled && act_edge &&
    (cap_mode || (mode == TPP_CAPCMP && started));
  wire logic gate_evt = enabled && mode == TPP_GATED && gate_end;

  // synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_s1 <= timer_in_i;
      in_s2 <= in_s1;
      in_prev <= in_s2;
    end
  end

  // prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i || !enabled) begin
      prescale_select_cnt <= 7'h00;
    end else if (prescale_select_tick) begin
      prescale_select_cnt <= 7'h00;
    end else begin
      prescale_select_cnt <= prescale_select_cnt + 7'h01;
    end
  end

  // start gate for capture/compare and triggered one-shot
  always_ff @(posedge clk_i) begin
    if (rst_i || !enabled) begin
      started <= 1'b0;
    end else if ((mode == TPP_CAPCMP || mode == TPP_TRIG) && act_edge) begin
      started <= 1'b1;
    end else if (mode == TPP_TRIG && reload) begin
      started <= 1'b0;
    end
  end

  // counter and capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= COUNT_INIT;
      capture <= 16'h0000;
    end else begin
      if (wr && adr_i == ADDR_COUNT) begin
        count <= dat_i[15:0];
      end else if (reload || (cap_evt && mode == TPP_CAPRST)) begin
        count <= COUNT_INIT;
      end else if (enabled && count_en) begin
        count <= count + 16'h0001;
      end
      if (cap_evt) begin
        capture <= count;
      end
    end
  end

  // primary output level before deadband
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_raw <= 1'b0;
    end else if (!enabled) begin
      out_raw <= io_polarity_bit;
    end else begin
      case (mode)
        TPP_ONESHOT: out_raw <= reload ? !io_polarity_bit : io_polarity_bit;
        TPP_PWM1, TPP_PWM2: begin
          if (reload) out_raw <= io_polarity_bit;
          else if (pwm_match) out_raw <= !io_polarity_bit;
        end
        default: if (reload) out_raw <= !out_raw;
      endcase
    end
  end

  // deadband: delays rising edges of both pins
  wire logic [7:0] db_len = (deadband_delay_field == 3'h0) ? 8'h00 :
    8'(9'h001 << deadband_delay_field);
  wire logic dual = enabled && mode == TPP_PWM2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      db_cnt <= 8'h00;
      out_q <= 1'b0;
      outn_q <= 1'b1;
    end else if (!dual) begin
      db_cnt <= 8'h00;
      out_q <= out_raw;
      outn_q <= !out_raw;
    end else if (out_q == out_raw && outn_q == !out_raw) begin
      db_cnt <= 8'h00;
    end else begin
      if (out_raw == 1'b0) out_q <= 1'b0;
      if (out_raw == 1'b1) outn_q <= 1'b0;
      if (db_cnt >= db_len) begin
        out_q <= out_raw;
        outn_q <= !out_raw;
        db_cnt <= 8'h00;
      end else begin
        db_cnt <= db_cnt + 8'h01;
      end
    end
  end
  assign timer_out_o = out_q;
  assign timer_out_n_o = outn_q;

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_one <= CTL1_RESET;
      ctl0 <= CTL0_RESET;
      reload_val <= RELOAD_RESET;
      pwm_val <= PWM_RESET;
      irq_en <= '0;
    end else begin
      if (wr && adr_i == ADDR_CTL1) timer_control_one <= dat_i[7:0];
      if (wr && adr_i == ADDR_CTL0) ctl0 <= dat_i[7:0];
      if (wr && adr_i == ADDR_IRQ_EN) irq_en <= dat_i[IRQ_N-1:0];
      if (wr && adr_i == ADDR_RELOAD) reload_val <= dat_i[15:0];
      if (wr && adr_i == ADDR_PWM) pwm_val <= dat_i[15:0];
      if (mode == TPP_TRIG && reload) timer_control_one[CTL1_EN_BIT] <= 1'b0;
      if (mode == TPP_ONESHOT && reload) timer_control_one[CTL1_EN_BIT] <= 1'b0;
    end
  end

  // sticky status, set wins over clear
  wire logic [IRQ_N-1:0] irq_set = {gate_evt, cap_evt, reload};
  wire logic [IRQ_N-1:0] irq_clr = (wr && adr_i == ADDR_IRQ_CLR) ? dat_i[IRQ_N-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end
  assign irq_o = |(irq_stat & irq_en);

  // read mux
  always_comb begin
    case (adr_i)
      ADDR_CTL1: next_dat = {24'h000000, timer_control_one};
      ADDR_CTL0: next_dat = {24'h000000, ctl0};
      ADDR_RELOAD: next_dat = {16'h0000, reload_val};
      ADDR_PWM: next_dat = {16'h0000, pwm_val};
      ADDR_COUNT: next_dat = {16'h0000, count};
      ADDR_CAPTURE: next_dat = {16'h0000, capture};
      ADDR_IRQ_STAT: next_dat = {29'h00000000, irq_stat};
      ADDR_IRQ_EN: next_dat = {29'h00000000, irq_en};
      default: next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= rd_req;
      if (rd_req && !we_i) dat_o <= next_dat;
    end
  end
endmodule : tpp_timer

// ### bench/tpp_pin_model.sv
// pin model: outside driver of the timer input pin
module tpp_pin_model (
  // clock and requested level
  input wire logic clk_i,
  input wire logic lvl_i,
  // pin
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 1'b0;
  // async pin, moves off the clock edge
  always @(posedge clk_i) begin
    pin_o <= #7 lvl_i;
  end
endmodule : tpp_pin_model

// ### bench/tpp_timer_monitor.sv
// checker: bus handshake and pin relations of the timer
module tpp_timer_monitor
  import tpp_pkg::*;
(
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins and interrupt
  input wire logic timer_in_i,
  input wire logic timer_out_o,
  input wire logic timer_out_n_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] c1;
  logic c0m;
  logic wr;
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  // shadow of control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1 <= CTL1_RESET;
      c0m <= 1'b0;
    end else if (wr && adr_i == ADDR_CTL1) begin
      c1 <= dat_i[7:0];
    end else if (wr && adr_i == ADDR_CTL0) begin
      c0m <= dat_i[CTL0_MODE3_BIT];
    end
  end
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_req_gets_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_idle_no_ack: assert property (!cyc_i |=> !ack_o) else $error("ack while idle");
  a_upper_bits_zero: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_unmapped_reads_zero: assert property (ack_o && !we_i && adr_i >= ADDR_IRQ_CLR |-> dat_o == 0)
    else $error("unmapped read not zero");
  a_idle_out_level: assert property (!c1[7] && $past(c1) == c1 && $past(c1, 2) == c1
    |-> timer_out_o == c1[CTL1_POL_BIT]) else $error("disabled output level");
  a_pwm2_no_overlap: assert property (c1[7] && $past(c1[7], 2) && {c0m, c1[2:0]} == TPP_PWM2
    |-> !(timer_out_o && timer_out_n_o)) else $error("outputs overlap");
  c_read: cover property (ack_o && !we_i);
  c_irq: cover property ($rose(irq_o));
  c_toggle: cover property (c1[7] && $changed(timer_out_o));
endmodule : tpp_timer_monitor

// ### bench/tpp_timer_bench.sv
// bench: register and pin sequences for the polarity/prescaler timer
module tpp_timer_bench
  import tpp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, pin_lvl = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, timer_in_i, timer_out_o, timer_out_n_o, irq_o;
  int error_cnt = 0, cmp_count = 0, cyc_n = 0, t;
  tpp_timer i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .timer_in_i, .timer_out_o, .timer_out_n_o, .irq_o);
  tpp_pin_model i_pin (.clk_i, .lvl_i(pin_lvl), .pin_o(timer_in_i));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic wait_tog(output int n);
    logic v;
    v = timer_out_o;
    n = 0;
    while (timer_out_o === v && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_tog
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_CTL1, 32'h0);
    rd(ADDR_RELOAD, 32'hffff);
    rd(ADDR_COUNT, 32'h1);
    rd(8'h24, 32'h0);
    wb(1'b1, ADDR_CTL1, 32'h40);
    repeat (3) @(posedge clk_i);
    chk({31'h0, timer_out_o}, 32'h1);
    wb(1'b1, ADDR_RELOAD, 32'h2);
    wb(1'b1, ADDR_IRQ_EN, 32'h1);
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, ADDR_CTL1, 32'h0);
      wb(1'b1, ADDR_COUNT, 32'h1);
      wb(1'b1, ADDR_CTL1, 32'h81 | (p << CTL1_PRESCALE_SELECT_LSB));
      wait_tog(t);
      wait_tog(t);
      chk(t, 2 << p);
    end
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, ADDR_CTL1, 32'h0);
    wb(1'b1, ADDR_IRQ_EN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h1);
    wb(1'b1, ADDR_IRQ_CLR, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h0);
    for (int pol = 0; pol < 2; pol++) begin
      wb(1'b1, ADDR_RELOAD, 32'hffff);
      wb(1'b1, ADDR_COUNT, 32'h1);
      wb(1'b1, ADDR_CTL1, 32'h82 | (pol << CTL1_POL_BIT));
      pin_lvl <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(ADDR_COUNT, pol ? 32'h1 : 32'h2);
      pin_lvl <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(ADDR_COUNT, 32'h2);
      wb(1'b1, ADDR_CTL1, 32'h0);
    end
    wb(1'b1, ADDR_COUNT, 32'h1);
    wb(1'b1, ADDR_CTL1, 32'h86);
    repeat (8) @(posedge clk_i);
    rd(ADDR_COUNT, 32'h1);
    pin_lvl <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin_lvl <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(ADDR_COUNT, 32'h5);
    rd(ADDR_IRQ_STAT, 32'h1 << IRQ_GATE);
    wb(1'b1, ADDR_CTL1, 32'h0);
    wb(1'b1, ADDR_CTL0, 32'h82);
    wb(1'b1, ADDR_RELOAD, 32'h8);
    wb(1'b1, ADDR_PWM, 32'h3);
    wb(1'b1, ADDR_COUNT, 32'h1);
    wb(1'b1, ADDR_CTL1, 32'h80);
    wait_tog(t);
    chk({31'h0, t < 2000}, 32'h1);
    chk({31'h0, timer_out_n_o}, 32'h0);
    wait_tog(t);
    chk(t, 32'h3);
    wb(1'b1, ADDR_CTL1, 32'h0);
    tally_and_finish();
  end
endmodule : tpp_timer_bench
bind tpp_timer tpp_timer_monitor i_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .timer_in_i, .timer_out_o, .timer_out_n_o, .irq_o);
